/* File: hw/rpc_rtc_power_ctrl.sv */
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ns
// How it works
// - With the wake pin set as output and the wake output level bit at 0 the wake pin is pulled low, at 1 its driver is released.
// - The wake direction bit selects input (0) or output (1) for the wake pin.
// - As input the wake pin is active high; as output it is open-drain, active low, pulled up outside.
// - Writing 1 to the reference power-down bit turns off regulators, reset comparator and reference.
// - After a full shutdown only a high wake pin, an enabled alarm or enabled periodic event restores power.
// - Writing 1 to the regulator power-down bit with the reference power-down bit at 0 turns off regulators and comparator, reference stays on.
// - After a regulator shutdown only the same three wake causes restore regulators and comparator.
// - The clock-out pin is enabled while the clock-out enable bit is 1 and disabled at 0.
module rpc_rtc_power_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic wake_pin_in,
    output logic wake_pin_out,
    output logic wake_pin_oe,
    input wire logic alarm_event,
    input wire logic alarm_enable,
    input wire logic periodic_event,
    input wire logic periodic_enable,
    output logic clock_out_pin_enable,
    output logic regulator_enable,
    output logic reset_comparator_enable,
    output logic reference_enable
);
    // ==========================================
    // Decode
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] rdata_next;
    logic wake_pin_direction;
    logic wake_pin_out_level;
    wire logic ctrl_hit;
    wire logic ctrl_wr;
    wire logic wake_pin_active;
    rpc_wake_if wif ();

    assign ctrl_hit = (reg_addr == rpc_pkg::RPC_CTRL_OFS);
    assign ctrl_wr = reg_wr && ctrl_hit;
    assign wake_pin_direction = ctrl_reg[rpc_pkg::RPC_WAKE_DIR_BIT];
    assign wake_pin_out_level = ctrl_reg[rpc_pkg::RPC_WAKE_OUT_BIT];
    assign wake_pin_active = !wake_pin_direction && wake_pin_in;

    // Power-down bits act as one-shot requests; state holds in the sequencer
    assign ctrl_next = ctrl_wr ? (reg_wdata & rpc_pkg::RPC_CTRL_MASK) : ctrl_reg;
    assign rdata_next = (reg_rd && ctrl_hit) ? ctrl_reg : 16'h0000;

    assign wif.wake_cause = wake_pin_active || (alarm_event && alarm_enable)
        || (periodic_event && periodic_enable);
    assign wif.ref_pd_req = ctrl_wr && reg_wdata[rpc_pkg::RPC_REF_PD_BIT];
    assign wif.reg_pd_req = ctrl_wr && reg_wdata[rpc_pkg::RPC_REG_PD_BIT];

    rpc_power_seq u_seq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .wif(wif)
    );

    // ==========================================
    // Registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= rpc_pkg::RPC_CTRL_RST;
            reg_rdata <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_pin_out <= 1'b0;
            wake_pin_oe <= 1'b0;
            clock_out_pin_enable <= 1'b0;
            regulator_enable <= 1'b1;
            reset_comparator_enable <= 1'b1;
            reference_enable <= 1'b1;
        end else begin
            wake_pin_out <= 1'b0;
            wake_pin_oe <= wake_pin_direction && !wake_pin_out_level;
            clock_out_pin_enable <= ctrl_reg[rpc_pkg::RPC_CLKOUT_BIT];
            regulator_enable <= wif.reg_on;
            reset_comparator_enable <= wif.reg_on;
            reference_enable <= wif.ref_on;
        end
    end

    // ==========================================
    // Checks
    wake_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wake_pin_oe |-> (!wake_pin_out && $past(wake_pin_direction)
        && !$past(wake_pin_out_level)))
        else $error("Wake pin driven against control");
    wake_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wake_pin_direction |=> !wake_pin_oe)
        else $error("Wake pin driven while input");
    ref_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wif.ref_pd_req && !wif.wake_cause) |=> ##1 (!reference_enable && !regulator_enable))
        else $error("Reference shutdown missed");
    ref_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wif.ref_on && !wif.wake_cause) |=> !wif.ref_on)
        else $error("Reference woke without cause");
    reg_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wif.reg_pd_req && !wif.ref_pd_req && wif.reg_on && !wif.wake_cause)
        |=> ##1 (!regulator_enable && reference_enable))
        else $error("Regulator shutdown wrong");
    reg_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wif.reg_on && wif.wake_cause) |=> ##1 (regulator_enable && reset_comparator_enable))
        else $error("Regulator wake missed");
    clkout_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 clock_out_pin_enable == $past(ctrl_reg[rpc_pkg::RPC_CLKOUT_BIT]))
        else $error("Clock out enable mismatch");
    reserved_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ctrl_wr |=> (ctrl_reg[15:5] == 11'h000))
        else $error("Reserved bits stored");

    // ==========================================
    // Further checks
    wake_out_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wake_pin_out)
        else $error("Wake pin output level not low");

    wake_release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wake_pin_out_level |=> !wake_pin_oe)
        else $error("Wake pin not released");

    wake_pull_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wake_pin_direction && !wake_pin_out_level) |=> wake_pin_oe)
        else $error("Wake pin not pulled low");

    wake_oe_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 wake_pin_oe == $past(wake_pin_direction && !wake_pin_out_level))
        else $error("Wake pin enable does not follow control");

    wake_in_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wake_pin_direction && wake_pin_in) |-> wif.wake_cause)
        else $error("High wake input ignored");

    wake_out_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wake_pin_direction && !(alarm_event && alarm_enable)
        && !(periodic_event && periodic_enable)) |-> !wif.wake_cause)
        else $error("Output wake pin taken as cause");

    alarm_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (alarm_event && alarm_enable) |-> wif.wake_cause)
        else $error("Enabled alarm ignored");

    periodic_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (periodic_event && periodic_enable) |-> wif.wake_cause)
        else $error("Enabled periodic event ignored");

    masked_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!alarm_enable && !periodic_enable && !wake_pin_active) |-> !wif.wake_cause)
        else $error("Masked event woke");

    ref_wake_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wif.ref_on && wif.wake_cause) |=> ##1 (reference_enable && regulator_enable))
        else $error("Reference wake missed");

    reg_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!wif.reg_on && !wif.wake_cause) |=> !wif.reg_on)
        else $error("Regulator woke without cause");

    ref_off_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reference_enable |-> (!regulator_enable && !reset_comparator_enable))
        else $error("Regulators on without reference");

    cmp_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        regulator_enable == reset_comparator_enable)
        else $error("Comparator and regulator differ");

    reg_keep_ref_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wif.reg_pd_req && !wif.ref_pd_req && wif.reg_on && !wif.wake_cause)
        |=> wif.ref_on)
        else $error("Reference lost on regulator shutdown");

    pd_none_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (ctrl_wr && !reg_wdata[rpc_pkg::RPC_REF_PD_BIT]
        && !reg_wdata[rpc_pkg::RPC_REG_PD_BIT] && wif.reg_on) |=> wif.reg_on)
        else $error("Shutdown without request");

    ref_req_now_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wif.ref_pd_req && !wif.wake_cause) |=> !wif.ref_on)
        else $error("Reference request not taken");

    ref_en_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 reference_enable == $past(wif.ref_on))
        else $error("Reference enable does not follow state");

    reg_en_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 regulator_enable == $past(wif.reg_on))
        else $error("Regulator enable does not follow state");

    clkout_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl_reg[rpc_pkg::RPC_CLKOUT_BIT] |=> !clock_out_pin_enable)
        else $error("Clock out enabled while bit clear");

    read_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !(reg_rd && ctrl_hit) |=> (reg_rdata == 16'h0000))
        else $error("Read data outside read cycle");

    read_data_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && ctrl_hit) |=> (reg_rdata == $past(ctrl_reg)))
        else $error("Read data wrong");

    ctrl_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !ctrl_wr |=> $stable(ctrl_reg))
        else $error("Control changed without write");
endmodule

/* File: hw/rpc_pkg.sv */
package rpc_pkg;
    // ==========================================
    // Register map
    localparam logic [15:0] RPC_CTRL_OFS = 16'h1930;
    localparam int RPC_DATA_W = 16;
    localparam logic [15:0] RPC_CTRL_RST = 16'h0010;
    localparam logic [15:0] RPC_CTRL_MASK = 16'h001f;
    // ==========================================
    // Field positions
    localparam int RPC_WAKE_OUT_BIT = 4;
    localparam int RPC_WAKE_DIR_BIT = 3;
    localparam int RPC_REF_PD_BIT = 2;
    localparam int RPC_REG_PD_BIT = 1;
    localparam int RPC_CLKOUT_BIT = 0;
    // ==========================================
    // Power states
    typedef enum logic [1:0] {
        RPC_ST_ON,
        RPC_ST_REG_OFF,
        RPC_ST_ALL_OFF
    } rpc_state_e;
endpackage

/* File: hw/rpc_wake_if.sv */
`timescale 1ns/1ns
// ==========================================
// Wake cause, power-down requests and power states between top and power sequencer
interface rpc_wake_if;
    logic wake_cause;
    logic ref_pd_req;
    logic reg_pd_req;
    logic ref_on;
    logic reg_on;
    modport top (output wake_cause, output ref_pd_req, output reg_pd_req,
        input ref_on, input reg_on);
    modport seq (input wake_cause, input ref_pd_req, input reg_pd_req,
        output ref_on, output reg_on);
endinterface

/* File: hw/rpc_power_seq.sv */
`timescale 1ns/1ns
// ==========================================
// Power-down sequencer: a one-cycle request shuts down, only a wake cause restores
module rpc_power_seq (
    input wire logic clk_sys,
    input wire logic rst_n,
    rpc_wake_if.seq wif
);
    rpc_pkg::rpc_state_e state_reg;
    rpc_pkg::rpc_state_e state_next;
    wire logic go_all_off;
    wire logic go_reg_off;

    assign go_all_off = wif.ref_pd_req;
    assign go_reg_off = wif.reg_pd_req && !wif.ref_pd_req;

    // ==========================================
    // Next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rpc_pkg::RPC_ST_ON: begin
                if (go_all_off) begin
                    state_next = rpc_pkg::RPC_ST_ALL_OFF;
                end else if (go_reg_off) begin
                    state_next = rpc_pkg::RPC_ST_REG_OFF;
                end
            end
            rpc_pkg::RPC_ST_REG_OFF: begin
                if (wif.wake_cause) begin
                    state_next = rpc_pkg::RPC_ST_ON;
                end else if (go_all_off) begin
                    state_next = rpc_pkg::RPC_ST_ALL_OFF;
                end
            end
            rpc_pkg::RPC_ST_ALL_OFF: begin
                if (wif.wake_cause) begin
                    state_next = rpc_pkg::RPC_ST_ON;
                end
            end
            default: state_next = rpc_pkg::RPC_ST_ON;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= rpc_pkg::RPC_ST_ON;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wif.reg_on = (state_reg == rpc_pkg::RPC_ST_ON);
    assign wif.ref_on = (state_reg != rpc_pkg::RPC_ST_ALL_OFF);
endmodule

/* File: bench/rpc_wake_src.sv */
`timescale 1ns/1ns
// ==========================================
// Outside wake source with pull-up on the open-drain wake pin
module rpc_wake_src (
    input wire logic pin_oe,
    input wire logic pin_out,
    input wire logic drive_en,
    input wire logic drive_level,
    output logic pin_level
);
    assign pin_level = pin_oe ? pin_out : (drive_en ? drive_level : 1'b1);
endmodule

/* File: bench/rpc_rtc_power_ctrl_tb.sv */
`timescale 1ns/1ns
module rpc_rtc_power_ctrl_tb;
    localparam logic [15:0] OFS = rpc_pkg::RPC_CTRL_OFS;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic ext_drv = 1'b0;
    logic [2:0] ev = 3'b000;
    logic [2:0] en = 3'b000;
    logic [15:0] reg_rdata;
    logic [15:0] rd_val;
    logic wake_pin_in, wake_pin_out, wake_pin_oe, clk_out_en, reg_en, cmp_en, ref_en;
    int err_count = 0;
    int n_compared = 0;
    always #10 clk_sys = ~clk_sys;
    rpc_rtc_power_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .wake_pin_in(wake_pin_in), .wake_pin_out(wake_pin_out), .wake_pin_oe(wake_pin_oe),
        .alarm_event(ev[1]), .alarm_enable(en[1]), .periodic_event(ev[2]),
        .periodic_enable(en[2]), .clock_out_pin_enable(clk_out_en),
        .regulator_enable(reg_en), .reset_comparator_enable(cmp_en),
        .reference_enable(ref_en));
    rpc_wake_src ext (.pin_oe(wake_pin_oe), .pin_out(wake_pin_out), .drive_en(ext_drv),
        .drive_level(ev[0]), .pin_level(wake_pin_in));
    // ==========================================
    // Access and compare tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic outs(input logic [15:0] exp);
        repeat (3) @(posedge clk_sys);
        #1 check({10'h000, wake_pin_out, clk_out_en, wake_pin_oe, reg_en, cmp_en, ref_en}, exp);
    endtask
    task automatic print_verdict;
        $display("Errors %0d, compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================
    // Tests
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(OFS);
        check(rd_val, rpc_pkg::RPC_CTRL_RST);
        outs(16'h0007);
        wr(OFS, 16'hffe1);
        rd(OFS);
        check(rd_val, 16'h0001);
        outs(16'h0017);
        wr(OFS, 16'h0008);
        outs(16'h000f);
        check({15'h0000, wake_pin_in}, 16'h0000);
        wr(OFS, 16'h0018);
        outs(16'h0007);
        check({15'h0000, wake_pin_in}, 16'h0001);
        wr(OFS, 16'h0000);
        outs(16'h0007);
        wr(16'h1932, 16'h0001);
        rd(16'h1932);
        check(rd_val, 16'h0000);
        rd(OFS);
        check(rd_val, 16'h0000);
        ext_drv <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 3; c++) begin
                wr(OFS, (m == 0) ? 16'h0004 : 16'h0002);
                ev <= 3'b110;
                en <= 3'b000;
                outs((m == 0) ? 16'h0000 : 16'h0001);
                ev <= 3'b001 << c;
                en <= 3'b110;
                outs(16'h0007);
                ev <= 3'b000;
            end
        end
        print_verdict();
    end
    initial begin
        #200000;
        err_count++;
        print_verdict();
    end
endmodule
